// File: core/hmi_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module hmi_host_port
  import hmi_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  hmi_bus_if.host                  bus,
  input  wire logic                muxModeSel,
  input  wire logic                rdWrVariantSel,
  input  wire logic                resetRequest,
  input  wire logic                cmdValid,
  input  wire logic                cmdWrite,
  input  wire logic [ADDR_W-1:0]   cmdAddr,
  input  wire logic [DATA_W-1:0]   cmdWdata,
  output logic                     cmdReady,
  output logic                     rspValid,
  output logic [DATA_W-1:0]        rspRdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge and data synchronisers
  logic [HOST_PIN_W-1:0] s1_reg;
  logic [HOST_PIN_W-1:0] s2_reg;
  logic [HOST_PIN_W-1:0] s3_reg;
  logic [HOST_PIN_W-1:0] in_reg;
  logic                  ackN;
  logic [DATA_W-1:0]     busData;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg <= HOST_PIN_IDLE;
      s2_reg <= HOST_PIN_IDLE;
      s3_reg <= HOST_PIN_IDLE;
      in_reg <= HOST_PIN_IDLE;
    end else begin
      s1_reg <= {bus.transferAcknowledgeN, bus.dataHighByte, bus.muxedLowBusLines};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      in_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & in_reg);
    end
  end

  assign {ackN, busData} = in_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer
  hmi_host_state_type    state_reg;
  logic [TIMER_W-1:0]    timer_reg;
  logic                  write_reg;
  logic [DATA_W-1:0]     wdata_reg;
  logic                  resetN_reg;
  logic                  mode_reg;
  logic                  variant_reg;
  logic                  csN_reg;
  logic                  latchStb_reg;
  logic                  strobe_reg;
  logic                  dir_reg;
  logic [ADDR_W-1:0]     addr_reg;
  logic [BYTE_W-1:0]     lowOut_reg;
  logic                  lowOe_reg;
  logic                  highOe_reg;
  logic                  ready_reg;
  logic                  rspValid_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic                  strobeIdle;
  logic                  strobeActive;
  logic                  dirActive;

  // Strobe levels per bus variant
  always_comb begin
    if (!mode_reg) begin
      strobeIdle   = 1'b1;
      strobeActive = 1'b0;
      dirActive    = !write_reg;
    end else if (variant_reg) begin
      strobeIdle   = 1'b1;
      strobeActive = write_reg;
      dirActive    = !write_reg;
    end else begin
      strobeIdle   = 1'b0;
      strobeActive = 1'b1;
      dirActive    = !write_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= HST_IDLE;
      timer_reg    <= TIMER_RESET;
      write_reg    <= 1'b0;
      wdata_reg    <= DATA_RESET;
      resetN_reg   <= 1'b1;
      mode_reg     <= 1'b0;
      variant_reg  <= 1'b0;
      csN_reg      <= 1'b1;
      latchStb_reg <= 1'b0;
      strobe_reg   <= 1'b1;
      dir_reg      <= 1'b1;
      addr_reg     <= ADDR_RESET;
      lowOut_reg   <= 8'h00;
      lowOe_reg    <= 1'b0;
      highOe_reg   <= 1'b0;
      ready_reg    <= 1'b0;
      rspValid_reg <= 1'b0;
      rdata_reg    <= DATA_RESET;
    end else begin
      rspValid_reg <= 1'b0;
      case (state_reg)
        HST_IDLE: begin
          mode_reg    <= muxModeSel;
          variant_reg <= rdWrVariantSel;
          ready_reg   <= 1'b1;
          strobe_reg  <= strobeIdle;
          if (resetRequest) begin
            ready_reg  <= 1'b0;
            resetN_reg <= 1'b0;
            timer_reg  <= 8'(RESET_HOLD_CYCLES - 1);
            state_reg  <= HST_RESET;
          end else if (cmdValid && ready_reg) begin
            ready_reg <= 1'b0;
            write_reg <= cmdWrite;
            wdata_reg <= cmdWdata;
            addr_reg  <= cmdAddr;
            timer_reg <= 8'(PHASE_CYCLES - 1);
            if (mode_reg) begin
              lowOut_reg <= cmdAddr;
              lowOe_reg  <= 1'b1;
              latchStb_reg <= 1'b1;
              state_reg  <= HST_ADDR;
            end else begin
              lowOut_reg <= cmdWdata[BYTE_W-1:0];
              lowOe_reg  <= cmdWrite;
              highOe_reg <= cmdWrite;
              state_reg  <= HST_LATCH;
            end
          end
        end
        HST_RESET: begin
          if (timer_reg == TIMER_RESET) begin
            resetN_reg <= 1'b1;
            timer_reg  <= 8'(PHASE_CYCLES - 1);
            state_reg  <= HST_GAP;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        HST_ADDR: begin
          if (timer_reg == TIMER_RESET) begin
            latchStb_reg <= 1'b0;
            timer_reg <= 8'(PHASE_CYCLES - 1);
            state_reg <= HST_LATCH;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        HST_LATCH: begin
          if (timer_reg == TIMER_RESET) begin
            lowOut_reg <= wdata_reg[BYTE_W-1:0];
            lowOe_reg  <= write_reg;
            highOe_reg <= write_reg;
            csN_reg    <= 1'b0;
            strobe_reg <= strobeActive;
            dir_reg    <= dirActive;
            state_reg  <= HST_STROBE;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        HST_STROBE: begin
          if (!ackN) begin
            rdata_reg <= busData;
            strobe_reg <= strobeIdle;
            dir_reg   <= 1'b1;
            lowOe_reg <= 1'b0;
            highOe_reg <= 1'b0;
            state_reg <= HST_END;
          end
        end
        HST_END: begin
          if (ackN) begin
            csN_reg      <= 1'b1;
            rspValid_reg <= 1'b1;
            timer_reg    <= 8'(PHASE_CYCLES - 1);
            state_reg    <= HST_GAP;
          end
        end
        HST_GAP: begin
          if (timer_reg == TIMER_RESET) begin
            state_reg <= HST_IDLE;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  assign bus.deviceResetN           = resetN_reg;
  assign bus.cpuInterfaceModeSelect = mode_reg;
  assign bus.muxStrobeRdWr          = variant_reg;
  assign bus.chipSelectN            = csN_reg;
  assign bus.addressLatchStrobe     = latchStb_reg;
  assign bus.dataStrobeOrRead       = strobe_reg;
  assign bus.directionOrWrite       = dir_reg;
  assign bus.directAddressLines     = addr_reg;
  assign bus.hostLowOut             = lowOut_reg;
  assign bus.hostLowOe              = lowOe_reg;
  assign bus.hostHighOut            = wdata_reg[DATA_W-1:BYTE_W];
  assign bus.hostHighOe             = highOe_reg;
  assign cmdReady                   = ready_reg;
  assign rspValid                   = rspValid_reg;
  assign rspRdata                   = rdata_reg;

endmodule
`default_nettype wire

// File: core/hmi_pkg.sv
// Overview of operation
// - Device reset clears counters and registers
// - Reset floats serial streams and data bus
// - Host holds reset low 100 ns minimum
// - Mode pin high muxed, low non-muxed
// - Non-muxed address from direct address lines
// - Muxed mode shares low lines for address
// - Host keeps latch strobe low non-muxed
// - Non-muxed access: strobe low with select
// - Muxed strobe variant: strobe high, select
// - Read strobe low drives both bytes
// - Direction input picks drive or receive
// - Write strobe low makes low lines inputs
// - Select high means port ignores access
// - Sixteen bit bus, low and high bytes
// - Acknowledge low marks transfer complete
// - Cycle end: acknowledge high, then float
package hmi_pkg;
  localparam int ADDR_W            = 8;
  localparam int BYTE_W            = 8;
  localparam int DATA_W            = 16;
  localparam int STREAM_COUNT      = 16;
  localparam int MEM_DEPTH         = 256;
  localparam int CLK_PERIOD_NS     = 25;
  localparam int RESET_MIN_NS      = 100;
  localparam int RESET_HOLD_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_CYCLES      = 4;
  localparam int TIMER_W           = 8;
  localparam int CTL_W             = 7;
  localparam int PIN_W             = CTL_W + ADDR_W + DATA_W;
  localparam int HOST_PIN_W        = 1 + DATA_W;
  // Control pins at rest: reset high, select high, strobes idle
  localparam logic [CTL_W-1:0]      CTL_IDLE      = 7'h4B;
  localparam logic [PIN_W-1:0]      PIN_IDLE      = {CTL_IDLE, 24'h000000};
  localparam logic [HOST_PIN_W-1:0] HOST_PIN_IDLE = {1'b1, 16'h0000};
  localparam logic [DATA_W-1:0]     DATA_RESET    = 16'h0000;
  localparam logic [ADDR_W-1:0]     ADDR_RESET    = 8'h00;
  localparam logic [TIMER_W-1:0]    TIMER_RESET   = 8'h00;

  typedef enum logic [3:0] {
    DEV_IDLE    = 4'b0001,
    DEV_ACCESS  = 4'b0010,
    DEV_ACK     = 4'b0100,
    DEV_RELEASE = 4'b1000
  } hmi_dev_state_type;

  typedef enum logic [6:0] {
    HST_IDLE   = 7'b0000001,
    HST_RESET  = 7'b0000010,
    HST_ADDR   = 7'b0000100,
    HST_LATCH  = 7'b0001000,
    HST_STROBE = 7'b0010000,
    HST_END    = 7'b0100000,
    HST_GAP    = 7'b1000000
  } hmi_host_state_type;

  // Per bit: take the new level once stages two and three agree
  function automatic logic [PIN_W-1:0] hmi_settle(input logic [PIN_W-1:0] s2,
                                                   input logic [PIN_W-1:0] s3,
                                                   input logic [PIN_W-1:0] held);
    hmi_settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
  endfunction
endpackage

// File: core/hmi_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hmi_bus_if;
  import hmi_pkg::*;
  logic                deviceResetN;
  logic                cpuInterfaceModeSelect;
  logic                muxStrobeRdWr;
  logic                chipSelectN;
  logic                addressLatchStrobe;
  logic                dataStrobeOrRead;
  logic                directionOrWrite;
  logic [ADDR_W-1:0]   directAddressLines;
  logic [BYTE_W-1:0]   hostLowOut;
  logic                hostLowOe;
  logic [BYTE_W-1:0]   hostHighOut;
  logic                hostHighOe;
  logic [BYTE_W-1:0]   devLowOut;
  logic                devLowOe;
  logic [BYTE_W-1:0]   devHighOut;
  logic                devHighOe;
  logic                devAckOut;
  logic                devAckOe;
  logic [BYTE_W-1:0]   muxedLowBusLines;
  logic [BYTE_W-1:0]   dataHighByte;
  logic                transferAcknowledgeN;

  // Wire levels: undriven data reads low, acknowledge has a pull-up
  assign muxedLowBusLines     = devLowOe ? devLowOut : (hostLowOe ? hostLowOut : 8'h00);
  assign dataHighByte         = devHighOe ? devHighOut : (hostHighOe ? hostHighOut : 8'h00);
  assign transferAcknowledgeN = devAckOe ? devAckOut : 1'b1;

  modport device (
    input  deviceResetN, cpuInterfaceModeSelect, muxStrobeRdWr, chipSelectN,
    input  addressLatchStrobe, dataStrobeOrRead, directionOrWrite, directAddressLines,
    input  muxedLowBusLines, dataHighByte,
    output devLowOut, devLowOe, devHighOut, devHighOe, devAckOut, devAckOe
  );
  modport host (
    output deviceResetN, cpuInterfaceModeSelect, muxStrobeRdWr, chipSelectN,
    output addressLatchStrobe, dataStrobeOrRead, directionOrWrite, directAddressLines,
    output hostLowOut, hostLowOe, hostHighOut, hostHighOe,
    input  muxedLowBusLines, dataHighByte, transferAcknowledgeN
  );
endinterface
`default_nettype wire

// File: core/hmi_device_port.sv
`timescale 1ns/1ps
`default_nettype none
module hmi_device_port
  import hmi_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  hmi_bus_if.device                    bus,
  output logic [STREAM_COUNT-1:0]      serialOutputStreams,
  output logic                         serialStreamsOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [PIN_W-1:0]      pinRaw;
  logic [PIN_W-1:0]      pinS1_reg;
  logic [PIN_W-1:0]      pinS2_reg;
  logic [PIN_W-1:0]      pinS3_reg;
  logic [PIN_W-1:0]      pin_reg;

  assign pinRaw = {bus.deviceResetN, bus.cpuInterfaceModeSelect, bus.muxStrobeRdWr,
                   bus.chipSelectN, bus.addressLatchStrobe, bus.dataStrobeOrRead,
                   bus.directionOrWrite, bus.directAddressLines,
                   bus.dataHighByte, bus.muxedLowBusLines};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinS1_reg <= PIN_IDLE;
      pinS2_reg <= PIN_IDLE;
      pinS3_reg <= PIN_IDLE;
      pin_reg   <= PIN_IDLE;
    end else begin
      pinS1_reg <= pinRaw;
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      pin_reg   <= hmi_settle(pinS2_reg, pinS3_reg, pin_reg);
    end
  end

  logic                  resetN;
  logic                  muxMode;
  logic                  rdWrVariant;
  logic                  csN;
  logic                  latchStrobe;
  logic                  strobe;
  logic                  direction;
  logic [ADDR_W-1:0]     directAddr;
  logic [BYTE_W-1:0]     lowIn;
  logic [BYTE_W-1:0]     highIn;
  logic                  rstInt;

  assign {resetN, muxMode, rdWrVariant, csN, latchStrobe, strobe, direction,
          directAddr, highIn, lowIn} = pin_reg;

  // Internal reset while the device reset pin is low
  assign rstInt = sys_rst | ~resetN;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  logic                  access;
  logic                  isRead;
  logic [ADDR_W-1:0]     latchedAddr_reg;
  logic [ADDR_W-1:0]     accessAddr;

  always_comb begin
    if (!muxMode) begin
      access = !csN && !strobe;
      isRead = direction;
    end else if (rdWrVariant) begin
      access = !csN && (!strobe || !direction);
      isRead = !strobe;
    end else begin
      access = !csN && strobe;
      isRead = direction;
    end
  end

  // Address from the shared low lines in muxed mode, from direct lines otherwise
  assign accessAddr = muxMode ? latchedAddr_reg : directAddr;

  // Latch follows the low lines while the strobe is high, holds after its fall
  always_ff @(posedge clk) begin
    if (rstInt) begin
      latchedAddr_reg <= ADDR_RESET;
    end else if (muxMode && latchStrobe) begin
      latchedAddr_reg <= lowIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal memory
  logic [DATA_W-1:0]     memory [MEM_DEPTH];
  logic [ADDR_W-1:0]     addr_reg;
  logic                  readAccess_reg;
  hmi_dev_state_type     state_reg;
  hmi_dev_state_type     state_next;

  always_ff @(posedge clk) begin
    if (state_reg == DEV_ACCESS && !readAccess_reg && !rstInt) begin
      memory[addr_reg] <= {highIn, lowIn};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_comb begin
    case (state_reg)
      DEV_IDLE: begin
        state_next = access ? DEV_ACCESS : DEV_IDLE;
      end
      DEV_ACCESS: begin
        state_next = DEV_ACK;
      end
      DEV_ACK: begin
        if (access) begin
          state_next = DEV_ACK;
        end else if (!csN) begin
          state_next = DEV_RELEASE;
        end else begin
          state_next = DEV_IDLE;
        end
      end
      DEV_RELEASE: begin
        state_next = DEV_IDLE;
      end
      default: begin
        state_next = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      state_reg <= DEV_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      addr_reg       <= ADDR_RESET;
      readAccess_reg <= 1'b0;
    end else if (state_reg == DEV_IDLE && access) begin
      addr_reg       <= accessAddr;
      readAccess_reg <= isRead;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data bus drivers
  logic [BYTE_W-1:0]     lowOut_reg;
  logic [BYTE_W-1:0]     highOut_reg;
  logic                  dataOe_reg;

  always_ff @(posedge clk) begin
    if (rstInt) begin
      lowOut_reg  <= 8'h00;
      highOut_reg <= 8'h00;
    end else if (state_reg == DEV_ACCESS && readAccess_reg) begin
      {highOut_reg, lowOut_reg} <= memory[addr_reg];
    end
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      dataOe_reg <= 1'b0;
    end else begin
      dataOe_reg <= state_next == DEV_ACK && readAccess_reg && !csN;
    end
  end

  assign bus.devLowOut  = lowOut_reg;
  assign bus.devHighOut = highOut_reg;
  assign bus.devLowOe   = dataOe_reg;
  assign bus.devHighOe  = dataOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer acknowledge
  logic                  ackOut_reg;
  logic                  ackOe_reg;

  always_ff @(posedge clk) begin
    if (rstInt) begin
      ackOut_reg <= 1'b1;
      ackOe_reg  <= 1'b0;
    end else begin
      ackOut_reg <= state_next != DEV_ACK;
      ackOe_reg  <= (state_next == DEV_ACK || state_next == DEV_RELEASE) && !csN;
    end
  end

  assign bus.devAckOut = ackOut_reg;
  assign bus.devAckOe  = ackOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial output streams
  logic [STREAM_COUNT-1:0] streams_reg;
  logic                    streamsOe_reg;

  always_ff @(posedge clk) begin
    if (rstInt) begin
      streams_reg   <= 16'h0000;
      streamsOe_reg <= 1'b0;
    end else begin
      streams_reg   <= 16'h0000;
      streamsOe_reg <= 1'b1;
    end
  end

  assign serialOutputStreams = streams_reg;
  assign serialStreamsOe     = streamsOe_reg;

endmodule
`default_nettype wire

// File: tb/hmi_bus_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hmi_bus_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic deviceResetN,
  input wire logic cpuInterfaceModeSelect,
  input wire logic muxStrobeRdWr,
  input wire logic chipSelectN,
  input wire logic addressLatchStrobe,
  input wire logic dataStrobeOrRead,
  input wire logic directionOrWrite,
  input wire logic devLowOe,
  input wire logic devHighOe,
  input wire logic devAckOut,
  input wire logic devAckOe,
  input wire logic transferAcknowledgeN,
  input wire logic serialStreamsOe
);
  ////////////////////////////////////////////////////////////////////////////////
  // Decoded host pins
  logic       rdWrMode;
  logic       readReq;
  logic       accessPins;
  logic [3:0] csHighCnt;

  assign rdWrMode   = cpuInterfaceModeSelect && muxStrobeRdWr;
  assign readReq    = rdWrMode ? !dataStrobeOrRead : directionOrWrite;
  assign accessPins = !chipSelectN && (rdWrMode ? (!dataStrobeOrRead || !directionOrWrite) :
                      (cpuInterfaceModeSelect ? dataStrobeOrRead : !dataStrobeOrRead));

  // Cycles that select has stayed high
  always_ff @(posedge clk) begin
    if (sys_rst || !chipSelectN) begin
      csHighCnt <= 4'h0;
    end else if (csHighCnt != 4'hF) begin
      csHighCnt <= csHighCnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_SYS_RESET_FLOAT: assert property ($fell(sys_rst) |->
    !devLowOe && !devHighOe && !devAckOe && !serialStreamsOe)
    else $error("outputs driven right after reset");
  AST_DEV_RESET_FLOAT: assert property ($fell(deviceResetN) |->
    ##6 (!devLowOe && !devHighOe && !devAckOe && !serialStreamsOe))
    else $error("outputs driven during device reset");
  AST_RESET_WIDTH: assert property ($fell(deviceResetN) |-> !deviceResetN [*4])
    else $error("device reset pulse too short");
  AST_LATCH_LOW_NONMUX: assert property (!cpuInterfaceModeSelect |-> !addressLatchStrobe)
    else $error("latch strobe high in non-muxed mode");
  AST_ACK_LATENCY: assert property ($rose(accessPins) |-> ##[2:10] !transferAcknowledgeN)
    else $error("no acknowledge after access");
  AST_ACK_HOLD: assert property ($fell(transferAcknowledgeN) |-> !transferAcknowledgeN [*5])
    else $error("acknowledge released too early");
  AST_READ_DRIVES: assert property ($fell(transferAcknowledgeN) && readReq |->
    devLowOe && devHighOe)
    else $error("read acknowledged without data drive");
  AST_WRITE_RECEIVES: assert property ($fell(transferAcknowledgeN) && !readReq |->
    !devLowOe && !devHighOe)
    else $error("device drives data on a write");
  AST_ACK_NEEDS_SELECT: assert property ($fell(transferAcknowledgeN) |->
    !chipSelectN && $past(!chipSelectN, 4))
    else $error("acknowledge without select");
  AST_ACK_END_HIGH: assert property ($rose(transferAcknowledgeN) && !chipSelectN |->
    devAckOe && devAckOut ##1 !devAckOe)
    else $error("acknowledge not driven high then floated");
  AST_DESELECT_FLOAT: assert property (csHighCnt >= 4'h6 |->
    !devLowOe && !devHighOe && !devAckOe)
    else $error("outputs driven while deselected");

  COV_NONMUX: cover property ($fell(transferAcknowledgeN) && !cpuInterfaceModeSelect);
  COV_MUX_STROBE: cover property ($fell(transferAcknowledgeN) && cpuInterfaceModeSelect &&
    !rdWrMode);
  COV_MUX_RDWR: cover property ($fell(transferAcknowledgeN) && rdWrMode && readReq);
  COV_DEV_RESET: cover property ($fell(deviceResetN));
endmodule
`default_nettype wire

// File: tb/host_microport_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module host_microport_interface_test;
  import hmi_pkg::*;
  logic              clk            = 1'b0;
  logic              sys_rst        = 1'b1;
  logic              muxModeSel     = 1'b0;
  logic              rdWrVariantSel = 1'b0;
  logic              resetRequest   = 1'b0;
  logic              cmdValid       = 1'b0;
  logic              cmdWrite       = 1'b0;
  logic [ADDR_W-1:0] cmdAddr        = 8'h00;
  logic [DATA_W-1:0] cmdWdata       = 16'h0000;
  logic              cmdReady;
  logic              rspValid;
  logic [DATA_W-1:0] rspRdata;
  logic              streamsOe;
  logic [STREAM_COUNT-1:0] streams;
  logic              ackPrev        = 1'b1;
  logic [DATA_W-1:0] wireWord;
  logic              wireCsN;
  logic [DATA_W-1:0] model [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] used [$];
  int                fails          = 0;
  int                compares       = 0;
  int unsigned       seed;

  ////////////////////////////////////////////////////////////////////////////////
  hmi_bus_if hmi_bus_if_i ();
  hmi_device_port hmi_device_port_i (.clk(clk), .sys_rst(sys_rst), .bus(hmi_bus_if_i),
    .serialOutputStreams(streams), .serialStreamsOe(streamsOe));
  hmi_host_port hmi_host_port_i (.clk(clk), .sys_rst(sys_rst), .bus(hmi_bus_if_i),
    .muxModeSel(muxModeSel), .rdWrVariantSel(rdWrVariantSel), .resetRequest(resetRequest),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspRdata(rspRdata));
  hmi_bus_assertions hmi_bus_assertions_i (.clk(clk), .sys_rst(sys_rst),
    .deviceResetN(hmi_bus_if_i.deviceResetN),
    .cpuInterfaceModeSelect(hmi_bus_if_i.cpuInterfaceModeSelect),
    .muxStrobeRdWr(hmi_bus_if_i.muxStrobeRdWr), .chipSelectN(hmi_bus_if_i.chipSelectN),
    .addressLatchStrobe(hmi_bus_if_i.addressLatchStrobe),
    .dataStrobeOrRead(hmi_bus_if_i.dataStrobeOrRead),
    .directionOrWrite(hmi_bus_if_i.directionOrWrite), .devLowOe(hmi_bus_if_i.devLowOe),
    .devHighOe(hmi_bus_if_i.devHighOe), .devAckOut(hmi_bus_if_i.devAckOut),
    .devAckOe(hmi_bus_if_i.devAckOe),
    .transferAcknowledgeN(hmi_bus_if_i.transferAcknowledgeN), .serialStreamsOe(streamsOe));

  always #12.5 clk = ~clk;

  // Captures the wire word and select as acknowledge falls
  always @(posedge clk) begin
    ackPrev <= hmi_bus_if_i.transferAcknowledgeN;
    if (ackPrev && !hmi_bus_if_i.transferAcknowledgeN) begin
      wireWord <= {hmi_bus_if_i.dataHighByte, hmi_bus_if_i.muxedLowBusLines};
      wireCsN  <= hmi_bus_if_i.chipSelectN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [DATA_W-1:0] expWord(input logic [ADDR_W-1:0] a);
    return model[a];
  endfunction

  function automatic logic [DATA_W-1:0] oeWord();
    return {12'h000, streamsOe, hmi_bus_if_i.devLowOe, hmi_bus_if_i.devHighOe,
            hmi_bus_if_i.devAckOe};
  endfunction

  task automatic setMode(input int m);
    @(negedge clk);
    muxModeSel     = (m != 0);
    rdWrVariantSel = (m == 2);
  endtask

  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdAddr  = a;
    cmdWdata = d;
    while (cmdReady !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmdValid = 1'b0;
    while (rspValid !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (wr) begin
      model[a] = d;
      used.push_back(a);
    end
    check("response", 16'h0001, {15'h0000, rspValid});
    check("bus word", expWord(a), wireWord);
    check("select at ack", 16'h0000, {15'h0000, wireCsN});
    if (!wr) check("read data", expWord(a), rspRdata);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int                n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    seed = $urandom(32'h19B0DDB1);
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    // Write and read back in every mode, corner values first
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 6; k++) begin
        addr = (k == 0) ? 8'h00 : ((k == 1) ? 8'hFF : ADDR_W'($urandom));
        data = (k == 0) ? 16'hA55A : ((k == 1) ? 16'hFFFF : DATA_W'($urandom));
        setMode(m);
        access(1'b1, addr, data);
        access(1'b0, addr, 16'h0000);
      end
      $display("test mode %0d done", m);
    end
    // Read back random written addresses, cycling through all three modes
    for (int k = 0; k < 12; k++) begin
      addr = used[$urandom_range(used.size() - 1)];
      setMode(k % 3);
      access(1'b0, addr, 16'h0000);
    end
    $display("test cross mode done");
    // Device reset pulse from the host
    @(negedge clk);
    resetRequest = 1'b1;
    n = 0;
    while (hmi_bus_if_i.deviceResetN !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    resetRequest = 1'b0;
    repeat (5) @(negedge clk);
    check("oe in device reset", 16'h0000, oeWord());
    check("ack wire in reset", 16'h0001, {15'h0000, hmi_bus_if_i.transferAcknowledgeN});
    access(1'b0, used[0], 16'h0000);
    $display("test device reset done");
    // System reset in mid-run
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    check("ready in reset", 16'h0000, {15'h0000, cmdReady});
    check("oe in reset", 16'h0000, oeWord());
    check("streams", 16'h0000, streams);
    sys_rst = 1'b0;
    access(1'b1, 8'h3C, 16'hC33C);
    access(1'b0, 8'h3C, 16'h0000);
    $display("test system reset done");
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[ERR] watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule
`default_nettype wire
